// *** prt_pkg.sv ***
// Constants, register map and field layout of the periodic timer.
// Assumes an APB master with 32-bit data and byte addresses.
// Behaviour
// - Flag sets on the tick that wraps the counter from wrap limit to zero
// - Flag clears by status read, then zero write
// - Overflow during clear sequence keeps flag set
// - Writing one to flag does nothing; reset clears
// - Enable bit gates overflow interrupt; reset clears
// - Halt bit freezes counter; reset sets halt
// - Clear bit zeroes counter, prescaler and low byte latch
// - Clear bit self-clears and reads zero
// - Halt plus clear together holds counter zero
// - Prescale field divides bus clock 1 to 64
// - High byte read latches low byte
// - Latched low byte kept until low read
// - Counter reads zero after reset or clear
// - At wrap limit, restart from zero next tick
// - Limit high write inhibits flag until low write
// - Reset sets both wrap limit bytes to ones
// - Sixteen-bit counter, reads never disturb counting
// - Break condition freezes the counter
// - Stop mode freezes timer, keeps all state
package prt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS_CONTROL = 10'h04B;
  localparam logic [9:0] IDX_COUNT_HIGH = 10'h04C;
  localparam logic [9:0] IDX_COUNT_LOW = 10'h04D;
  localparam logic [9:0] IDX_LIMIT_HIGH = 10'h04E;
  localparam logic [9:0] IDX_LIMIT_LOW = 10'h04F;

  ////////////////////////////////////////////////////////////////////////////
  // Status/control bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_HALT = 5;
  localparam int BIT_CLEAR = 4;
  localparam int BIT_SEL_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_MAX = 3'h6;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0] PRESCALE_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible control fields
  typedef struct packed {
    logic irq_enable;
    logic halt;
    logic [2:0] sel;
  } prt_ctrl_type;

  localparam prt_ctrl_type CTRL_RESET = '{irq_enable: 1'b0, halt: 1'b1, sel: SEL_RESET};

endpackage

// *** prt_timer.sv ***
// Periodic interrupt timer with an APB register slave.
// Assumes a single clock pclk; break and stop inputs come from logic on pclk.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module prt_timer
  import prt_pkg::*;
(
  input wire logic pclk, // Bus clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic break_active, // Debug break, freezes counter
  input wire logic stop_mode, // Stop mode, freezes counter and prescaler
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic irq // Level interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  prt_ctrl_type ctrl_ff;
  logic flag_ff;
  logic arm_ff;
  logic inhibit_ff;
  logic [15:0] count_ff;
  logic [5:0] prescale_ff;
  logic [7:0] limit_hi_ff;
  logic [7:0] limit_lo_ff;
  logic [7:0] held_lo_ff;
  logic held_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;

  logic setup;
  logic access;
  logic [9:0] idx;
  logic wr_status;
  logic rd_status;
  logic wr_limit_hi;
  logic wr_limit_lo;
  logic rd_count_lo;
  logic clear_req;
  logic running;
  logic tick;
  logic ovf_evt;
  logic [5:0] tick_mask;
  logic [31:0] nxt_prdata;
  logic nxt_err;

  // Address match against a register index
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    return a == r;
  endfunction

  // Prescaler mask for a select code; codes above six act as six
  function automatic logic [5:0] sel_mask(input logic [2:0] s);
    logic [2:0] c;
    c = (s > SEL_MAX) ? SEL_MAX : s;
    case (c)
      3'h0: sel_mask = 6'h00;
      3'h1: sel_mask = 6'h01;
      3'h2: sel_mask = 6'h03;
      3'h3: sel_mask = 6'h07;
      3'h4: sel_mask = 6'h0F;
      3'h5: sel_mask = 6'h1F;
      default: sel_mask = 6'h3F;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; effects happen at the completing access edge
  assign setup = psel && !penable;
  assign access = psel && penable && pready_ff;
  assign idx = paddr[11:2];
  assign wr_status = access && pwrite && hit(idx, IDX_STATUS_CONTROL);
  assign rd_status = access && !pwrite && hit(idx, IDX_STATUS_CONTROL);
  assign wr_limit_hi = access && pwrite && hit(idx, IDX_LIMIT_HIGH);
  assign wr_limit_lo = access && pwrite && hit(idx, IDX_LIMIT_LOW);
  assign rd_count_lo = access && !pwrite && hit(idx, IDX_COUNT_LOW);
  assign clear_req = wr_status && pwdata[BIT_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // Counting enables and prescaled tick
  assign running = !ctrl_ff.halt && !break_active && !stop_mode;
  assign tick_mask = sel_mask(ctrl_ff.sel);
  assign tick = running && ((prescale_ff & tick_mask) == tick_mask);
  assign ovf_evt = tick && (count_ff == {limit_hi_ff, limit_lo_ff});

  // Read data mux, sampled in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (hit(idx, IDX_STATUS_CONTROL)) begin
      nxt_prdata[7:0] = {flag_ff, ctrl_ff.irq_enable, ctrl_ff.halt, 1'b0, 1'b0, ctrl_ff.sel};
    end else if (hit(idx, IDX_COUNT_HIGH)) begin
      nxt_prdata[7:0] = count_ff[15:8];
    end else if (hit(idx, IDX_COUNT_LOW)) begin
      nxt_prdata[7:0] = held_ff ? held_lo_ff : count_ff[7:0];
    end else if (hit(idx, IDX_LIMIT_HIGH)) begin
      nxt_prdata[7:0] = limit_hi_ff;
    end else if (hit(idx, IDX_LIMIT_LOW)) begin
      nxt_prdata[7:0] = limit_lo_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait state, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_err;
      end else if (access) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields; halt set at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_status) begin
      ctrl_ff.irq_enable <= pwdata[BIT_IRQ_ENABLE];
      ctrl_ff.halt <= pwdata[BIT_HALT];
      ctrl_ff.sel <= pwdata[BIT_SEL_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_ff <= PRESCALE_RESET;
      count_ff <= COUNT_RESET;
    end else if (clear_req) begin
      prescale_ff <= PRESCALE_RESET;
      count_ff <= COUNT_RESET;
    end else if (running) begin
      prescale_ff <= prescale_ff + 6'h01;
      if (ovf_evt) begin
        count_ff <= COUNT_RESET;
      end else if (tick) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte holding buffer for coherent 16-bit reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_ff <= 1'b0;
      held_lo_ff <= 8'h00;
    end else if (clear_req) begin
      held_ff <= 1'b0;
      held_lo_ff <= 8'h00;
    end else if (setup && !pwrite && hit(idx, IDX_COUNT_HIGH) && !held_ff) begin
      held_ff <= 1'b1;
      held_lo_ff <= count_ff[7:0];
    end else if (rd_count_lo) begin
      held_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap limit bytes and the write interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_hi_ff <= LIMIT_RESET;
      limit_lo_ff <= LIMIT_RESET;
      inhibit_ff <= 1'b0;
    end else if (wr_limit_hi) begin
      limit_hi_ff <= pwdata[7:0];
      inhibit_ff <= 1'b1;
    end else if (wr_limit_lo) begin
      limit_lo_ff <= pwdata[7:0];
      inhibit_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag and its two-step clear; a new overflow wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else if (ovf_evt && !inhibit_ff) begin
      flag_ff <= 1'b1;
      arm_ff <= 1'b0;
    end else if (wr_status) begin
      if (arm_ff && !pwdata[BIT_FLAG]) begin
        flag_ff <= 1'b0;
      end
      arm_ff <= 1'b0;
    end else if (rd_status && flag_ff) begin
      arm_ff <= 1'b1;
    end
  end

  // Interrupt request register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && ctrl_ff.irq_enable;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_armed_read;
    rd_status && flag_ff && !ovf_evt;
  endsequence

  sequence s_zero_write;
    arm_ff && wr_status && !pwdata[BIT_FLAG] && !(ovf_evt && !inhibit_ff);
  endsequence

  property p_flag_set;
    ovf_evt && !inhibit_ff |=> flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on overflow");

  property p_clear_seq;
    s_armed_read ##[2:21] s_zero_write |=> !flag_ff;
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("flag not cleared");

  property p_unarmed_keep;
    flag_ff && wr_status && !arm_ff |=> flag_ff;
  endproperty
  a_unarmed_keep: assert property (p_unarmed_keep) else $error("flag lost");

  property p_no_spurious;
    !flag_ff && !(ovf_evt && !inhibit_ff) |=> !flag_ff;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without overflow");

  property p_irq;
    ##1 irq == ($past(flag_ff) && $past(ctrl_ff.irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_halt_hold;
    (ctrl_ff.halt || break_active || stop_mode) && !clear_req |=> $stable(count_ff);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved while frozen");

  property p_clear;
    clear_req |=> count_ff == COUNT_RESET && prescale_ff == PRESCALE_RESET && !held_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_wrap;
    ovf_evt && !clear_req |=> count_ff == COUNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero");

  property p_inhibit;
    inhibit_ff && !flag_ff |=> !flag_ff;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("flag set during interlock");

  property p_div1;
    running && ctrl_ff.sel == SEL_RESET |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed tick");

  property p_clear_reads_zero;
    setup && !pwrite && hit(idx, IDX_STATUS_CONTROL) |=> prdata[BIT_CLEAR] == 1'b0;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read one");

  // Counter parked at zero over two cycles
  sequence s_parked_zero;
    count_ff == COUNT_RESET ##1 count_ff == COUNT_RESET;
  endsequence

  // A status read with the flag set arms the clear
  property p_arm;
    s_armed_read |=> arm_ff;
  endproperty
  a_arm: assert property (p_arm) else $error("clear not armed by read");

  // A new overflow cancels a pending clear
  property p_ovf_disarm;
    ovf_evt && !inhibit_ff |=> !arm_ff;
  endproperty
  a_ovf_disarm: assert property (p_ovf_disarm) else $error("armed after overflow");

  // Writing one to the flag never clears it
  property p_one_write;
    flag_ff && wr_status && pwdata[BIT_FLAG] |=> flag_ff;
  endproperty
  a_one_write: assert property (p_one_write) else $error("flag lost on one write");

  // Interrupt request stays low while the enable bit is clear
  property p_irq_gate;
    !ctrl_ff.irq_enable |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  // A frozen timer keeps its prescaler phase
  property p_hold_div;
    !running && !clear_req |=> $stable(prescale_ff);
  endproperty
  a_hold_div: assert property (p_hold_div) else $error("prescaler moved");

  // Stop mode can never raise the flag
  property p_stop_no_flag;
    stop_mode && !flag_ff |=> !flag_ff;
  endproperty
  a_stop_no_flag: assert property (p_stop_no_flag) else $error("flag set in stop");

  // Halt and clear in one write keep the counter at zero
  property p_park;
    clear_req && pwdata[BIT_HALT] |=> s_parked_zero;
  endproperty
  a_park: assert property (p_park) else $error("counter left zero while parked");

  // Each tick below the wrap limit adds exactly one
  property p_step;
    tick && !ovf_evt && !clear_req |=> count_ff == $past(count_ff) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");

  // Code seven ticks only at the full six-bit prescaler
  property p_sel_top;
    tick && ctrl_ff.sel > SEL_MAX |-> &prescale_ff;
  endproperty
  a_sel_top: assert property (p_sel_top) else $error("code seven not slowest");

  // Latched low byte is kept until the low byte is read
  property p_latch_hold;
    held_ff && !rd_count_lo && !clear_req |=> held_ff && $stable(held_lo_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched low byte changed");

  // A low byte read while latched returns the latched byte
  property p_latch_read;
    setup && !pwrite && hit(idx, IDX_COUNT_LOW) && held_ff |=> prdata[7:0] == held_lo_ff;
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("low read not latched");

  // Limit high write arms the interlock
  property p_lock_set;
    wr_limit_hi |=> inhibit_ff;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("interlock not set");

  // Limit low write releases the interlock
  property p_lock_free;
    wr_limit_lo |=> !inhibit_ff;
  endproperty
  a_lock_free: assert property (p_lock_free) else $error("interlock not released");

endmodule

`default_nettype wire

// *** periodic_interrupt_timer_tb_top.sv ***
// Self-checking bench for the periodic timer behind an APB register slave.
// Assumes prt_pkg and prt_timer compiled first; one 40 MHz clock drives all.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk_val(32'(g), 32'(e))

module periodic_interrupt_timer_tb_top
  import prt_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic break_active = 1'b0;
  logic stop_mode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int run_all = 0;
  int run_base = 0;
  int div = 1;
  int snap = 0;
  bit mdl_run = 1'b0;
  logic [15:0] rnd = 16'h8A2E;

  prt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .break_active(break_active),
    .stop_mode(stop_mode), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and a running-cycle model of the counter
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mdl_run && !break_active && !stop_mode) run_all <= run_all + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Allows a couple of ticks of slack between model and design
  function automatic logic near(input logic [31:0] g, input int e);
    return (g + 2 >= e) && (g <= e + 2);
  endfunction

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%08h exp=%08h", $time, g, e);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    snap = (run_all - run_base) / div;
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Status writes also steer the bench model of halt, clear and divider
  task automatic wr_reg(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    if (idx == IDX_STATUS_CONTROL) begin
      mdl_run = !d[BIT_HALT];
      div = 1 << ((d[2:0] == 3'h7) ? 6 : d[2:0]);
      if (d[BIT_CLEAR]) run_base = run_all;
    end
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    `CHK(r, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic e;
    int lat;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every register
    rd_chk(IDX_STATUS_CONTROL, 32'h20);
    rd_chk(IDX_COUNT_HIGH, 32'h00);
    rd_chk(IDX_COUNT_LOW, 32'h00);
    rd_chk(IDX_LIMIT_HIGH, 32'hFF);
    rd_chk(IDX_LIMIT_LOW, 32'hFF);
    // Counter stays halted; count write ignored; unmapped places refused
    apb(1'b1, IDX_COUNT_LOW, {24'h0, rnd[7:0]}, d, e);
    idle(40);
    rd_chk(IDX_COUNT_LOW, 32'h00);
    apb(1'b1, 10'h050, {16'h0, rnd}, d, e);
    `CHK(e, 1'b1);
    apb(1'b0, 10'h04A, 32'h0, d, e);
    `CHK(e, 1'b1);
    // Every prescale code, clear reads back zero, random run lengths
    for (int s = 0; s < 8; s++) begin
      wr_reg(IDX_STATUS_CONTROL, 32'h10 | s);
      rnd = lfsr(rnd);
      idle(150 + rnd[5:0]);
      rd_chk(IDX_STATUS_CONTROL, s);
      apb(1'b0, IDX_COUNT_LOW, 32'h0, d, e);
      `CHK(near(d, snap), 1'b1);
    end
    // Low byte latch across break and stop, which both freeze counting
    wr_reg(IDX_STATUS_CONTROL, 32'h16);
    idle(200);
    apb(1'b0, IDX_COUNT_HIGH, 32'h0, d, e);
    `CHK(d, 32'h00);
    lat = snap;
    break_active <= 1'b1;
    idle(300);
    break_active <= 1'b0;
    stop_mode <= 1'b1;
    idle(300);
    rd_chk(IDX_STATUS_CONTROL, 32'h06);
    stop_mode <= 1'b0;
    idle(300);
    apb(1'b0, IDX_COUNT_HIGH, 32'h0, d, e);
    apb(1'b0, IDX_COUNT_LOW, 32'h0, d, e);
    `CHK(near(d, lat), 1'b1);
    apb(1'b0, IDX_COUNT_LOW, 32'h0, d, e);
    `CHK(near(d, snap), 1'b1);
    // Latch taken during a break is released before the break ends
    break_active <= 1'b1;
    idle(4);
    apb(1'b0, IDX_COUNT_HIGH, 32'h0, d, e);
    `CHK(d, 32'h00);
    apb(1'b0, IDX_COUNT_LOW, 32'h0, d, e);
    `CHK(near(d, snap), 1'b1);
    break_active <= 1'b0;
    // Limit high write inhibits the flag until the low byte lands
    wr_reg(IDX_LIMIT_HIGH, 32'h00);
    wr_reg(IDX_STATUS_CONTROL, 32'h10);
    idle(300);
    rd_chk(IDX_STATUS_CONTROL, 32'h00);
    wr_reg(IDX_STATUS_CONTROL, 32'h10);
    wr_reg(IDX_LIMIT_LOW, 32'h05);
    idle(20);
    rd_chk(IDX_STATUS_CONTROL, 32'h80);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IDX_COUNT_LOW, 32'h0, d, e);
      `CHK(d <= 32'h5, 1'b1);
    end
    `CHK(irq, 1'b0);
    // Flag set stays on a one write and on a zero write without a read
    wr_reg(IDX_STATUS_CONTROL, 32'hE0);
    idle(2);
    `CHK(irq, 1'b1);
    wr_reg(IDX_STATUS_CONTROL, 32'h60);
    rd_chk(IDX_STATUS_CONTROL, 32'hE0);
    wr_reg(IDX_STATUS_CONTROL, 32'h60);
    idle(2);
    rd_chk(IDX_STATUS_CONTROL, 32'h60);
    `CHK(irq, 1'b0);
    // Overflow between the read and the zero write keeps the flag
    wr_reg(IDX_STATUS_CONTROL, 32'h40);
    idle(20);
    rd_chk(IDX_STATUS_CONTROL, 32'hC0);
    idle(20);
    wr_reg(IDX_STATUS_CONTROL, 32'h40);
    rd_chk(IDX_STATUS_CONTROL, 32'hC0);
    // Halt with clear parks the counter at zero, limit low byte untouched
    wr_reg(IDX_STATUS_CONTROL, 32'hB0);
    idle(50);
    rd_chk(IDX_COUNT_HIGH, 32'h00);
    rd_chk(IDX_COUNT_LOW, 32'h00);
    rd_chk(IDX_LIMIT_LOW, 32'h05);
    rd_chk(IDX_STATUS_CONTROL, 32'hA0);
    // Reset in mid-run clears the set flag and restores defaults
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    mdl_run = 1'b0;
    rd_chk(IDX_STATUS_CONTROL, 32'h20);
    rd_chk(IDX_LIMIT_LOW, 32'hFF);
    `CHK(irq, 1'b0);
    final_report();
  end
endmodule

`undef CHK
`default_nettype wire
